// ==== exec_pkg.sv ====
// Package for the emulated-operation execution block
package exec_pkg;

	// ----------------------------------------
	// Status word bit positions
	// ----------------------------------------
	localparam int CARRY_BIT = 0;
	localparam int ZERO_BIT = 1;
	localparam int NEG_BIT = 2;
	localparam int GIE_BIT = 3;
	localparam int CORE_HALT_BIT = 4;
	localparam int OSC_OFF_BIT = 5;
	localparam int OVF_BIT = 8;

	// ----------------------------------------
	// Constants
	// ----------------------------------------
	localparam logic [15:0] IRQ_DIS_MASK = 16'hFFF7;
	localparam logic [15:0] IRQ_EN_MASK = 16'h0008;
	localparam logic [15:0] WORD_ONES = 16'hFFFF;
	localparam logic [15:0] BYTE_ONES = 16'h00FF;
	localparam logic [15:0] STATUS_RST = 16'h0000;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [15:0] PC_STEP = 16'h0002;

	// ----------------------------------------
	// Register map (APB byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] OPERAND_OFS = 8'h04;
	localparam logic [7:0] RESULT_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] PC_OFS = 8'h10;
	localparam logic [7:0] IRQ_OFS = 8'h14;

	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BYTE_BIT = 4;
	localparam int CMD_OFF_LSB = 16;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_SUB2 = 4'h1,
		OP_ADD1 = 4'h2,
		OP_ADD2 = 4'h3,
		OP_INV = 4'h4,
		OP_IRQ_DIS = 4'h5,
		OP_IRQ_EN = 4'h6,
		OP_BR_C = 4'h7,
		OP_BR_Z = 4'h8
	} op_e;

	typedef struct packed {
		logic neg;
		logic zero;
		logic carry;
		logic ovf;
	} flags_s;

	typedef struct packed {
		logic [15:0] value;
		flags_s flags;
	} alu_res_s;

endpackage

// ==== exec_alu.sv ====
// Arithmetic unit for the emulated increment, decrement and invert operations
`timescale 1ns/1ns
module exec_alu (
	// Operation
	input wire logic [3:0] op_i,
	input wire logic byte_i,
	input wire logic [15:0] dst_i,
	// Result
	output exec_pkg::alu_res_s res_o
);

	// ----------------------------------------
	// Width helpers
	// ----------------------------------------
	function automatic logic [15:0] trim(input logic [15:0] v, input logic b);
		trim = b ? (v & exec_pkg::BYTE_ONES) : v;
	endfunction

	function automatic logic sign_of(input logic [15:0] v, input logic b);
		sign_of = b ? v[7] : v[15];
	endfunction

	logic [15:0] src;
	logic [15:0] sum;
	logic [16:0] ext;
	logic [16:0] addend;
	logic carry_out;

	always_comb begin
		src = trim(dst_i, byte_i);
		addend = 17'h00000;
		ext = 17'h00000;
		sum = 16'h0000;
		carry_out = 1'b0;
		res_o = '0;
		unique case (exec_pkg::op_e'(op_i))
			exec_pkg::OP_ADD1, exec_pkg::OP_ADD2: begin
				addend = (exec_pkg::op_e'(op_i) == exec_pkg::OP_ADD1) ? 17'h00001 : 17'h00002;
				ext = {1'b0, src} + addend;
				sum = trim(ext[15:0], byte_i);
				carry_out = byte_i ? ext[8] : ext[16];
				res_o.value = sum;
				res_o.flags.zero = (sum == 16'h0000);
				res_o.flags.carry = carry_out;
				res_o.flags.neg = sign_of(sum, byte_i);
				// Positive source turning negative: overflow
				res_o.flags.ovf = !sign_of(src, byte_i) && sign_of(sum, byte_i);
			end
			exec_pkg::OP_SUB2: begin
				ext = {1'b0, src} + {1'b0, trim(16'hFFFE, byte_i)};
				sum = trim(ext[15:0], byte_i);
				res_o.value = sum;
				res_o.flags.neg = sign_of(sum, byte_i);
				res_o.flags.zero = (src == 16'h0002);
				res_o.flags.carry = (src > 16'h0001);
				res_o.flags.ovf = sign_of(src, byte_i) && !sign_of(sum, byte_i);
			end
			exec_pkg::OP_INV: begin
				sum = src ^ (byte_i ? exec_pkg::BYTE_ONES : exec_pkg::WORD_ONES);
				res_o.value = sum;
				res_o.flags.zero = (sum == 16'h0000);
				res_o.flags.carry = (sum != 16'h0000);
				res_o.flags.ovf = sign_of(src, byte_i);
				res_o.flags.neg = sign_of(sum, byte_i);
			end
			default: begin
				res_o.value = src;
			end
		endcase
	end

endmodule // exec_alu

// ==== exec_core.sv ====
// Execution block for emulated arithmetic, interrupt-enable and conditional jump operations
//
// Contract
// - Subtract two, flag negative from result sign
// - Zero when operand was two; carry unless 0/1
// - Overflow on 8001h/8000h or 81h/80h
// - Disable clears enable bit, others untouched
// - Enable sets enable bit, others untouched
// - One instruction runs before pending interrupt
// - Add one; zero and carry on all-ones
// - Add one overflow on largest positive value
// - Add two; zero on FFFEh, carry FFFEh/FFFFh
// - Add two overflow on 7FFEh/7FFFh, 7Eh/7Fh
// - Invert: carry is not-zero, overflow from sign
// - Carry jump adds twice signed offset
// - Zero jump adds twice signed offset
// - Jumps leave arithmetic flags unchanged
// - Arithmetic ops keep mode and enable bits
`timescale 1ns/1ns
module exec_core (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Interrupt request from the system
	input wire logic irq_req_i,
	output logic irq_take_o
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic wr_en;
	logic addr_ok;

	assign addr_ok = (paddr_i == exec_pkg::CMD_OFS) || (paddr_i == exec_pkg::OPERAND_OFS) ||
		(paddr_i == exec_pkg::RESULT_OFS) || (paddr_i == exec_pkg::STATUS_OFS) ||
		(paddr_i == exec_pkg::PC_OFS) || (paddr_i == exec_pkg::IRQ_OFS);
	assign wr_en = psel_i && penable_i && pwrite_i && addr_ok;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !addr_ok;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] operand_r;
	logic [15:0] result_r;
	logic [15:0] status_word_r;
	logic [15:0] pc_r;
	logic shield_r;
	logic irq_take_r;

	logic cmd_go;
	logic [3:0] op;
	logic byte_sel;
	logic [9:0] offset;
	exec_pkg::alu_res_s alu_res;

	assign cmd_go = wr_en && (paddr_i == exec_pkg::CMD_OFS);
	assign op = pwdata_i[exec_pkg::CMD_OP_LSB +: 4];
	assign byte_sel = pwdata_i[exec_pkg::CMD_BYTE_BIT];
	assign offset = pwdata_i[exec_pkg::CMD_OFF_LSB +: 10];

	exec_alu i_exec_alu (
		.op_i(op),
		.byte_i(byte_sel),
		.dst_i(operand_r),
		.res_o(alu_res)
	);

	function automatic logic is_arith(input logic [3:0] o);
		is_arith = (o == exec_pkg::OP_SUB2) || (o == exec_pkg::OP_ADD1) ||
			(o == exec_pkg::OP_ADD2) || (o == exec_pkg::OP_INV);
	endfunction

	function automatic logic [15:0] branch_target(input logic [15:0] pc, input logic [9:0] ofs);
		branch_target = pc + exec_pkg::PC_STEP + {{5{ofs[9]}}, ofs, 1'b0};
	endfunction

	// ----------------------------------------
	// Operand and result
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			operand_r <= 16'h0000;
		end else if (wr_en && paddr_i == exec_pkg::OPERAND_OFS) begin
			operand_r <= pwdata_i[15:0];
		end else if (cmd_go && is_arith(op)) begin
			operand_r <= alu_res.value;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			result_r <= 16'h0000;
		end else if (cmd_go && is_arith(op)) begin
			result_r <= alu_res.value;
		end
	end

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			status_word_r <= exec_pkg::STATUS_RST;
		end else if (wr_en && paddr_i == exec_pkg::STATUS_OFS) begin
			status_word_r <= pwdata_i[15:0];
		end else if (cmd_go) begin
			unique case (exec_pkg::op_e'(op))
				exec_pkg::OP_SUB2, exec_pkg::OP_ADD1, exec_pkg::OP_ADD2, exec_pkg::OP_INV: begin
					// Only arithmetic flags move; mode bits kept
					status_word_r[exec_pkg::NEG_BIT] <= alu_res.flags.neg;
					status_word_r[exec_pkg::ZERO_BIT] <= alu_res.flags.zero;
					status_word_r[exec_pkg::CARRY_BIT] <= alu_res.flags.carry;
					status_word_r[exec_pkg::OVF_BIT] <= alu_res.flags.ovf;
				end
				exec_pkg::OP_IRQ_DIS: status_word_r <= status_word_r & exec_pkg::IRQ_DIS_MASK;
				exec_pkg::OP_IRQ_EN: status_word_r <= status_word_r | exec_pkg::IRQ_EN_MASK;
				default: status_word_r <= status_word_r;
			endcase
		end
	end

	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pc_r <= exec_pkg::PC_RST;
		end else if (wr_en && paddr_i == exec_pkg::PC_OFS) begin
			pc_r <= pwdata_i[15:0];
		end else if (cmd_go && op != exec_pkg::OP_NONE) begin
			if (op == exec_pkg::OP_BR_C && status_word_r[exec_pkg::CARRY_BIT]) begin
				pc_r <= branch_target(pc_r, offset);
			end else if (op == exec_pkg::OP_BR_Z && status_word_r[exec_pkg::ZERO_BIT]) begin
				pc_r <= branch_target(pc_r, offset);
			end else begin
				pc_r <= pc_r + exec_pkg::PC_STEP;
			end
		end
	end

	// ----------------------------------------
	// Interrupt acceptance
	// ----------------------------------------
	// Shield set by enable, cleared when the next instruction runs
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			shield_r <= 1'b0;
		end else if (cmd_go && op != exec_pkg::OP_NONE) begin
			shield_r <= (op == exec_pkg::OP_IRQ_EN);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_take_r <= 1'b0;
		end else begin
			irq_take_r <= irq_req_i && status_word_r[exec_pkg::GIE_BIT] && !shield_r &&
				!(cmd_go && op == exec_pkg::OP_IRQ_EN);
		end
	end
	assign irq_take_o = irq_take_r;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prdata_o <= 32'h00000000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			unique case (paddr_i)
				exec_pkg::OPERAND_OFS: prdata_o <= {16'h0000, operand_r};
				exec_pkg::RESULT_OFS: prdata_o <= {16'h0000, result_r};
				exec_pkg::STATUS_OFS: prdata_o <= {16'h0000, status_word_r};
				exec_pkg::PC_OFS: prdata_o <= {16'h0000, pc_r};
				exec_pkg::IRQ_OFS: prdata_o <= {30'h00000000, irq_take_r, shield_r};
				default: prdata_o <= 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Command of one kind, with a qualifier on the same edge
	sequence cmd_s(logic [3:0] c, logic q);
		cmd_go && op == c && q;
	endsequence

	// Two edges with no acceptance while the shield stands
	sequence no_take_s;
		!irq_take_r ##1 (!irq_take_r || !shield_r);
	endsequence

	property flag_hold_p;
		@(posedge mclk_i) disable iff (rst_i)
		(cmd_go && (op == exec_pkg::OP_BR_C || op == exec_pkg::OP_BR_Z)) |=> status_word_r == $past(status_word_r);
	endproperty

	// Subtract two
	sub_two_value_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_SUB2, !byte_sel) |=> result_r == 16'($past(operand_r) - 16'h0002))
		else $error("subtract two result wrong");
	sub_two_neg_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_SUB2, byte_sel) |=> status_word_r[exec_pkg::NEG_BIT] == result_r[7])
		else $error("subtract two negative flag wrong");
	sub_two_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_SUB2, 1'b1) |=> status_word_r[exec_pkg::ZERO_BIT] == ($past(operand_r[7:0]) == 8'h02 &&
		($past(byte_sel) || $past(operand_r[15:8]) == 8'h00)))
		else $error("subtract two zero flag wrong");
	sub_two_carry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_SUB2, !byte_sel) |=> status_word_r[exec_pkg::CARRY_BIT] == ($past(operand_r) > 16'h0001))
		else $error("subtract two carry wrong");
	sub_two_ovf_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_SUB2, !byte_sel && (operand_r == 16'h8000 || operand_r == 16'h8001))
		|=> status_word_r[exec_pkg::OVF_BIT])
		else $error("subtract two overflow missing");
	sub_byte_ovf_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_SUB2, byte_sel) |=> status_word_r[exec_pkg::OVF_BIT] ==
		($past(operand_r[7:0]) == 8'h80 || $past(operand_r[7:0]) == 8'h81))
		else $error("subtract two byte overflow wrong");

	// Interrupt enable bit and acceptance
	irq_dis_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_IRQ_DIS, !(wr_en && paddr_i == exec_pkg::STATUS_OFS))
		|=> status_word_r == ($past(status_word_r) & exec_pkg::IRQ_DIS_MASK))
		else $error("disable did not clear enable bit");
	irq_dis_take_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_IRQ_DIS, 1'b1) |-> ##2 !irq_take_r)
		else $error("interrupt taken after disable");
	irq_en_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_IRQ_EN, 1'b1) |=> status_word_r == ($past(status_word_r) | exec_pkg::IRQ_EN_MASK))
		else $error("enable did not set enable bit");
	irq_shield_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_IRQ_EN, 1'b1) |=> no_take_s)
		else $error("interrupt taken before next instruction");
	shield_take_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		shield_r |=> !irq_take_r)
		else $error("interrupt taken while shielded");

	// Add one and add two
	add_one_value_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_ADD1, !byte_sel) |=> result_r == 16'($past(operand_r) + 16'h0001))
		else $error("add one result wrong");
	add_one_zc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_ADD1, byte_sel && operand_r[7:0] == 8'hFF)
		|=> status_word_r[exec_pkg::ZERO_BIT] && status_word_r[exec_pkg::CARRY_BIT])
		else $error("add one wrap flags wrong");
	add_one_ovf_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_ADD1, !byte_sel) |=> status_word_r[exec_pkg::OVF_BIT] == ($past(operand_r) == 16'h7FFF))
		else $error("add one overflow wrong");
	add_two_value_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_ADD2, byte_sel) |=> result_r == {8'h00, 8'($past(operand_r[7:0]) + 8'h02)})
		else $error("add two byte result wrong");
	add_two_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_ADD2, byte_sel) |=> status_word_r[exec_pkg::ZERO_BIT] == ($past(operand_r[7:0]) == 8'hFE))
		else $error("add two zero wrong");
	add_two_carry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_ADD2, !byte_sel) |=> status_word_r[exec_pkg::CARRY_BIT] == ($past(operand_r) >= 16'hFFFE))
		else $error("add two carry wrong");
	add_two_ovf_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_ADD2, !byte_sel) |=> status_word_r[exec_pkg::OVF_BIT] ==
		($past(operand_r) == 16'h7FFE || $past(operand_r) == 16'h7FFF))
		else $error("add two overflow wrong");

	// Invert
	inv_value_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_INV, !byte_sel) |=> operand_r == ~$past(operand_r))
		else $error("invert result wrong");
	inv_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_INV, byte_sel) |=> status_word_r[exec_pkg::ZERO_BIT] == ($past(operand_r[7:0]) == 8'hFF))
		else $error("invert zero wrong");
	inv_carry_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_INV, 1'b1) |=> status_word_r[exec_pkg::CARRY_BIT] != status_word_r[exec_pkg::ZERO_BIT])
		else $error("invert carry not complement of zero");
	inv_ovf_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_INV, !byte_sel) |=> status_word_r[exec_pkg::OVF_BIT] == $past(operand_r[15]))
		else $error("invert overflow wrong");

	// Jumps, mode bits and byte-form upper byte
	br_carry_pc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_BR_C, status_word_r[exec_pkg::CARRY_BIT])
		|=> pc_r == branch_target($past(pc_r), $past(offset)))
		else $error("carry jump target wrong");
	br_carry_fall_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_BR_C, !status_word_r[exec_pkg::CARRY_BIT]) |=> pc_r == 16'($past(pc_r) + exec_pkg::PC_STEP))
		else $error("carry jump not sequential");
	br_zero_pc_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_s(exec_pkg::OP_BR_Z, status_word_r[exec_pkg::ZERO_BIT])
		|=> pc_r == 16'($past(pc_r) + exec_pkg::PC_STEP + 16'(signed'($past(offset))) * 16'h0002))
		else $error("zero jump target wrong");
	jump_flags_a: assert property (flag_hold_p) else $error("jump changed flags");
	mode_bits_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_go && is_arith(op) |=> status_word_r[exec_pkg::OSC_OFF_BIT:exec_pkg::GIE_BIT] ==
		$past(status_word_r[exec_pkg::OSC_OFF_BIT:exec_pkg::GIE_BIT]))
		else $error("arithmetic op changed mode bits");
	byte_upper_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		cmd_go && is_arith(op) && byte_sel |=> operand_r[15:8] == 8'h00 && result_r[15:8] == 8'h00)
		else $error("byte form touched upper byte");

endmodule // exec_core

// ==== test_cpu_emulated_ops_and_jumps.sv ====
// Self-checking testbench for the emulated-operation execution block
`timescale 1ns/1ns
module test_cpu_emulated_ops_and_jumps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq_req = 1'b0;
	logic irq_take;
	int mismatches = 0;
	int n_compared = 0;
	logic [15:0] pc_exp;
	logic [15:0] st;
	logic [15:0] v;
	logic [19:0] e;
	logic [9:0] off;
	logic [31:0] rd;
	logic err;
	logic [15:0] corners [15] = '{16'h0000, 16'h0001, 16'h0002, 16'h007E, 16'h007F, 16'h0080, 16'h0081,
		16'h00FE, 16'h00FF, 16'h7FFE, 16'h7FFF, 16'h8000, 16'h8001, 16'hFFFE, 16'hFFFF};

	exec_core i_exec_core (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.psel_i(psel),
		.penable_i(penable),
		.pwrite_i(pwrite),
		.paddr_i(paddr),
		.pwdata_i(pwdata),
		.prdata_o(prdata),
		.pready_o(pready),
		.pslverr_o(pslverr),
		.irq_req_i(irq_req),
		.irq_take_o(irq_take)
	);

	initial forever #20 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		do begin
			@(posedge mclk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Issue a command and track the expected program counter
	task automatic exe(input logic [3:0] op, input logic b, input logic [9:0] o);
		logic t;
		t = (op == exec_pkg::OP_BR_C && st[0]) || (op == exec_pkg::OP_BR_Z && st[1]);
		apb(1'b1, exec_pkg::CMD_OFS, {6'h00, o, 11'h000, b, op});
		if (op != exec_pkg::OP_NONE) pc_exp = pc_exp + 16'h0002 + (t ? {{5{o[9]}}, o, 1'b0} : 16'h0000);
	endtask

	// Expected {result, n, z, c, v} of an arithmetic operation
	function automatic logic [19:0] model(input logic [3:0] op, input logic b, input logic [15:0] x);
		logic [15:0] m, a, r, h;
		logic z, c, o;
		m = b ? 16'h00FF : 16'hFFFF;
		a = x & m;
		h = m >> 1;
		case (op)
			exec_pkg::OP_SUB2: begin
				r = (a - 16'h0002) & m;
				z = (a == 16'h0002);
				c = (a > 16'h0001);
				o = (a == h + 16'h0001) || (a == h + 16'h0002);
			end
			exec_pkg::OP_ADD1: begin
				r = (a + 16'h0001) & m;
				z = (a == m);
				c = z;
				o = (a == h);
			end
			exec_pkg::OP_ADD2: begin
				r = (a + 16'h0002) & m;
				z = (a == m - 16'h0001);
				c = (a >= m - 16'h0001);
				o = (a == h) || (a == h - 16'h0001);
			end
			default: begin
				r = a ^ m;
				z = (a == m);
				c = !z;
				o = b ? a[7] : a[15];
			end
		endcase
		return {r, (b ? r[7] : r[15]), z, c, o};
	endfunction

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		#(40 * 30000);
		mismatches++;
		summarize();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'hB1EF));
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		pc_exp = 16'h0000;
		st = 16'h0000;
		apb(1'b0, exec_pkg::STATUS_OFS, 32'h0);
		check("status reset", rd, 32'h0);
		apb(1'b0, exec_pkg::PC_OFS, 32'h0);
		check("pc reset", rd, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		for (int op = 1; op <= 4; op++) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < 25; i++) begin
					v = (i < 15) ? corners[i] : 16'($urandom);
					st = 16'($urandom) & 16'h013F;
					apb(1'b1, exec_pkg::STATUS_OFS, {16'h0000, st});
					apb(1'b1, exec_pkg::OPERAND_OFS, {16'h0000, v});
					exe(4'(op), b[0], 10'($urandom));
					e = model(4'(op), b[0], v);
					apb(1'b0, exec_pkg::OPERAND_OFS, 32'h0);
					check("operand", rd, {16'h0000, e[19:4]});
					apb(1'b0, exec_pkg::RESULT_OFS, 32'h0);
					check("result", rd, {16'h0000, e[19:4]});
					apb(1'b0, exec_pkg::STATUS_OFS, 32'h0);
					check("flags", rd, {16'h0000, (st & 16'h0038) | {7'h00, e[0], 5'h00, e[3:1]}});
					apb(1'b0, exec_pkg::PC_OFS, 32'h0);
					check("pc arith", rd, {16'h0000, pc_exp});
				end
			end
		end
		for (int i = 0; i < 48; i++) begin
			st = 16'($urandom) & 16'h013F;
			off = (i < 8) ? (i[2] ? 10'h1FF : 10'h200) : 10'($urandom);
			apb(1'b1, exec_pkg::STATUS_OFS, {16'h0000, st});
			exe(4'(5 + i % 4), 1'b0, off);
			if (i % 4 == 0) st = st & exec_pkg::IRQ_DIS_MASK;
			if (i % 4 == 1) st = st | exec_pkg::IRQ_EN_MASK;
			apb(1'b0, exec_pkg::STATUS_OFS, 32'h0);
			check("status mode", rd, {16'h0000, st});
			apb(1'b0, exec_pkg::PC_OFS, 32'h0);
			check("pc jump", rd, {16'h0000, pc_exp});
		end
		st = 16'h0000;
		apb(1'b1, exec_pkg::STATUS_OFS, 32'h0);
		irq_req <= 1'b1;
		exe(exec_pkg::OP_IRQ_EN, 1'b0, 10'h000);
		st = 16'h0008;
		repeat (3) @(posedge mclk_i);
		#1 check("take shielded", {31'h0, irq_take}, 32'h0);
		apb(1'b0, exec_pkg::IRQ_OFS, 32'h0);
		check("irq reg shield", rd, 32'h1);
		exe(exec_pkg::OP_BR_Z, 1'b0, 10'h005);
		repeat (2) @(posedge mclk_i);
		#1 check("take open", {31'h0, irq_take}, 32'h1);
		apb(1'b0, exec_pkg::IRQ_OFS, 32'h0);
		check("irq reg take", rd, 32'h2);
		exe(exec_pkg::OP_IRQ_DIS, 1'b0, 10'h000);
		exe(exec_pkg::OP_NONE, 1'b0, 10'h000);
		repeat (2) @(posedge mclk_i);
		#1 check("take masked", {31'h0, irq_take}, 32'h0);
		irq_req <= 1'b0;
		apb(1'b0, exec_pkg::PC_OFS, 32'h0);
		check("pc final", rd, {16'h0000, pc_exp});
		summarize();
	end

endmodule // test_cpu_emulated_ops_and_jumps
